// ==== wd_params.svh ====
`ifndef WD_PARAMS_SVH
`define WD_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define WD_ADDR_FAULT 9'h005
`define WD_ADDR_EVENT 9'h006
`define WD_ADDR_MASK 9'h00a
`define WD_ADDR_CTRL_B 9'h00f
`define WD_ADDR_CTRL_D 9'h011
`define WD_ADDR_CTRL_F 9'h013
`define WD_ADDR_CFG 9'h0fe
`define WD_ADDR_STAT 9'h0ff

// ----------------------------------------
// Field positions
// ----------------------------------------
`define WD_FAULT_TO_BIT 0
`define WD_EVT_WARN_BIT 3
`define WD_RETRY_LSB 5
`define WD_SCALE_LSB 0
`define WD_KICK_BIT 0
`define WD_CFG_LEVEL_BIT 0
`define WD_CFG_PINKICK_BIT 1
`define WD_CFG_SECRST_BIT 2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define WD_MASK_RST 8'h00
`define WD_RETRY_RST 2'h3
`define WD_SCALE_RST 3'h0
`define WD_CFG_RST 3'h0

// ----------------------------------------
// Timing, in slow clock ticks
// ----------------------------------------
`define WD_BASE_TICKS 20'h00800
`define WD_MIN_REFRESH_TICKS 16'h0020

`endif

// ==== wd_pkg.sv ====
package wd_pkg;

   // Host register access, one cycle per strobe
   typedef struct packed {
      logic rd;
      logic wr;
      logic [8:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   // Requests from the power manager
   typedef struct packed {
      logic active_entry;
      logic pd_done;
   } pm_req_t;

   // Answers to the power manager
   typedef struct packed {
      logic active_ok;
      logic shutdown_req;
      logic restart_req;
      logic frozen;
   } pm_resp_t;

   typedef enum logic [2:0] {
      WD_IDLE,
      WD_ARMING,
      WD_RUN,
      WD_SHUTDOWN,
      WD_FROZEN
   } wd_state_t;

   typedef struct packed {
      wd_state_t st;
      logic [19:0] cnt;
      logic [15:0] since_kick;
      logic [2:0] scale;
      logic [1:0] retry_field;
      logic [1:0] retry_cnt;
      logic fault_to;
      logic evt_warn;
      logic [7:0] mask;
      logic [2:0] cfg;
      logic bypass;
      logic strap_taken;
      logic [7:0] rdata;
      logic shut_pulse;
      logic restart_pulse;
   } wd_regs_t;

   typedef struct packed {
      logic [2:0] s1;
      logic [2:0] s2;
      logic [2:0] s3;
   } sync_regs_t;

endpackage : wd_pkg

// ==== wd_sync_edge.sv ====
`timescale 1ns/10ps
module wd_sync_edge (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_b_in,
   // Asynchronous levels
   input wire logic [2:0] async_in,
   // Synchronised level and rising edge
   output logic [2:0] level_out,
   output logic [2:0] rise_out
);
   import wd_pkg::*;

   sync_regs_t q;
   sync_regs_t d;

   // ----------------------------------------
   // Two-stage synchroniser, third stage only for edges
   // ----------------------------------------
   always_comb begin
      d = q;
      d.s1 = async_in;
      d.s2 = q.s1;
      d.s3 = q.s2;
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // First stage is never looked at here
   assign level_out = q.s2;
   assign rise_out = q.s2 & ~q.s3;
endmodule : wd_sync_edge

// ==== wd_watchdog.sv ====
// Overview of operation
// - Expiry without refresh sets timeout fault flag and requests shutdown to low_power_state.
// - Enabled watchdog cannot be stopped unless the OTP unlock strap allows it.
// - Count on crystal slow clock when valid, else internal slow clock.
// - After cold boot the watchdog arms when the active state is entered.
// - Host gives first refresh; active transition completes only after it.
// - Maskable warning event raised at half the period without refresh.
// - Refresh by control register kick bit or edge on kick input pin.
// - Level mode accepts pulse or held kick; minimum interval not enforced.
// - Secondary reset output asserted during power-down after a timeout.
// - Retry counter decrements by one on every timeout, holding at zero.
// - Retry counter at zero keeps device in low_power_state, no restart.
// - Retry counter loads from the software-programmed retry count field.
`timescale 1ns/10ps
`include "wd_params.svh"
module wd_watchdog (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_b_in,
   // Host register port
   input wire wd_pkg::reg_req_t reg_req_in,
   output logic [7:0] reg_rdata_out,
   // Power manager handshake
   input wire wd_pkg::pm_req_t pm_req_in,
   output wd_pkg::pm_resp_t pm_resp_out,
   // Slow clocks and crystal status, asynchronous
   input wire logic xtal_clk_in,
   input wire logic int_slow_clk_in,
   input wire logic xtal_ok_in,
   // First GPIO as kick input, asynchronous
   input wire logic kick_input_pin_in,
   // OTP unlock strap
   input wire logic otp_wd_unlock_in,
   // Interrupt and secondary reset
   output logic warn_irq_out,
   output logic sec_reset_out
);
   import wd_pkg::*;

   wd_regs_t q;
   wd_regs_t d;
   logic [2:0] lvl;
   logic [2:0] rise;
   logic [2:0] lvl_ok;

   // ----------------------------------------
   // Synchronisers for pins and slow clocks
   // ----------------------------------------
   wd_sync_edge u_sync (
      .core_clk_in(core_clk_in),
      .rst_b_in(rst_b_in),
      .async_in({kick_input_pin_in, int_slow_clk_in, xtal_clk_in}),
      .level_out(lvl),
      .rise_out(rise)
   );

   // Crystal valid flag on its own pair; only bit 0 carries a signal
   wd_sync_edge u_sync_ok (
      .core_clk_in(core_clk_in),
      .rst_b_in(rst_b_in),
      .async_in({2'b00, xtal_ok_in}),
      .level_out(lvl_ok),
      .rise_out()
   );

   // Period in slow ticks; scale 0 means disabled
   function automatic logic [19:0] period_of(input logic [2:0] scale);
      logic [2:0] sh;
      sh = scale - 3'h1;
      period_of = `WD_BASE_TICKS << sh;
   endfunction : period_of

   // Register write strobe decode
   function automatic logic wr_hit(input reg_req_t r, input logic [8:0] a);
      wr_hit = r.wr && (r.addr == a);
   endfunction : wr_hit

   logic tick;
   logic xtal_ok;
   logic level_mode;
   logic reg_kick;
   logic pin_kick;
   logic kick;
   logic [19:0] period;
   logic [19:0] cnt_next;
   logic timeout;
   logic warn_set;
   logic [7:0] rd_mux;

   // ----------------------------------------
   // Tick source, kicks and period compare
   // ----------------------------------------
   always_comb begin
      xtal_ok = lvl_ok[0];
      // Crystal valid flag is a slow level, crossing via its own pair
      tick = xtal_ok ? rise[0] : rise[1];
      level_mode = q.cfg[`WD_CFG_LEVEL_BIT];
      reg_kick = wr_hit(reg_req_in, `WD_ADDR_CTRL_F)
                 && reg_req_in.wdata[`WD_KICK_BIT];
      // Held input counts as a kick on every cycle in level mode
      pin_kick = q.cfg[`WD_CFG_PINKICK_BIT]
                 && (level_mode ? lvl[2] : rise[2]);
      // Too-early kicks are ignored unless level mode waives the minimum
      kick = (reg_kick || pin_kick)
             && (level_mode || (q.since_kick >= `WD_MIN_REFRESH_TICKS));
      period = period_of(q.scale);
      cnt_next = q.cnt + 20'h00001;
      timeout = (q.st == WD_ARMING || q.st == WD_RUN) && !kick
                && tick && (cnt_next >= period);
      warn_set = (q.st == WD_ARMING || q.st == WD_RUN) && !kick
                 && tick && (cnt_next == (period >> 1));
   end

   // ----------------------------------------
   // Read data mux
   // ----------------------------------------
   always_comb begin
      case (reg_req_in.addr)
         `WD_ADDR_FAULT: rd_mux = {7'h00, q.fault_to};
         `WD_ADDR_EVENT: rd_mux = {4'h0, q.evt_warn, 3'h0};
         `WD_ADDR_MASK: rd_mux = q.mask;
         `WD_ADDR_CTRL_B: rd_mux = {1'b0, q.retry_field, 5'h00};
         `WD_ADDR_CTRL_D: rd_mux = {5'h00, q.scale};
         `WD_ADDR_CFG: rd_mux = {5'h00, q.cfg};
         `WD_ADDR_STAT: rd_mux = {q.retry_cnt, q.bypass, 2'h0, 3'(q.st)};
         default: rd_mux = 8'h00; // Kick register and unmapped read zero
      endcase
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      d = q;
      d.shut_pulse = 1'b0;
      d.restart_pulse = 1'b0;
      if (reg_req_in.rd) begin
         d.rdata = rd_mux;
      end

      // Strap caught once, the first cycle after reset release
      if (!q.strap_taken) begin
         d.strap_taken = 1'b1;
         d.bypass = otp_wd_unlock_in;
      end

      // Plain configuration writes
      if (wr_hit(reg_req_in, `WD_ADDR_MASK)) begin
         d.mask = reg_req_in.wdata;
      end
      if (wr_hit(reg_req_in, `WD_ADDR_CFG)) begin
         d.cfg = reg_req_in.wdata[2:0];
      end
      if (wr_hit(reg_req_in, `WD_ADDR_CTRL_B)) begin
         d.retry_field = reg_req_in.wdata[`WD_RETRY_LSB +: 2];
         d.retry_cnt = reg_req_in.wdata[`WD_RETRY_LSB +: 2];
      end
      // Disabling a live watchdog is locked out without the strap
      if (wr_hit(reg_req_in, `WD_ADDR_CTRL_D)) begin
         if (q.st == WD_IDLE || q.bypass
             || reg_req_in.wdata[`WD_SCALE_LSB +: 3] != 3'h0) begin
            d.scale = reg_req_in.wdata[`WD_SCALE_LSB +: 3];
         end
      end

      // Sticky flags: hardware set wins over write-one-to-clear
      if (wr_hit(reg_req_in, `WD_ADDR_EVENT)
          && reg_req_in.wdata[`WD_EVT_WARN_BIT]) begin
         d.evt_warn = 1'b0;
      end
      if (wr_hit(reg_req_in, `WD_ADDR_FAULT)
          && reg_req_in.wdata[`WD_FAULT_TO_BIT]) begin
         d.fault_to = 1'b0;
      end
      if (warn_set) begin
         d.evt_warn = 1'b1;
      end

      // Period counting, shared by arming and running
      if (q.st == WD_ARMING || q.st == WD_RUN) begin
         if (kick) begin
            d.cnt = 20'h00000;
            d.since_kick = 16'h0000;
         end else if (tick) begin
            d.cnt = cnt_next;
            if (q.since_kick != 16'hffff) begin
               d.since_kick = q.since_kick + 16'h0001;
            end
         end
      end

      case (q.st)
         WD_IDLE: begin
            if (pm_req_in.active_entry && q.scale != 3'h0) begin
               d.st = WD_ARMING;
               d.cnt = 20'h00000;
               d.since_kick = 16'hffff; // First kick never too early
            end
         end
         WD_ARMING: begin
            if (timeout) begin
               d.st = WD_SHUTDOWN;
            end else if (kick) begin
               d.st = WD_RUN;
            end
         end
         WD_RUN: begin
            if (timeout) begin
               d.st = WD_SHUTDOWN;
            end else if (q.scale == 3'h0) begin
               d.st = WD_IDLE; // Only reachable through the strap
            end
         end
         WD_SHUTDOWN: begin
            if (pm_req_in.pd_done) begin
               if (q.retry_cnt == 2'h0) begin
                  d.st = WD_FROZEN;
               end else begin
                  d.st = WD_IDLE;
                  d.restart_pulse = 1'b1;
               end
            end
         end
         WD_FROZEN: begin
            d.st = WD_FROZEN; // Left only by reset
         end
         default: begin
            d.st = WD_IDLE;
         end
      endcase

      // Timeout side effects
      if (timeout) begin
         d.fault_to = 1'b1;
         d.shut_pulse = 1'b1;
         if (q.retry_cnt != 2'h0) begin
            d.retry_cnt = q.retry_cnt - 2'h1;
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         q <= '0;
         q.st <= WD_IDLE;
         q.scale <= `WD_SCALE_RST;
         q.retry_field <= `WD_RETRY_RST;
         q.retry_cnt <= `WD_RETRY_RST;
         q.mask <= `WD_MASK_RST;
         q.cfg <= `WD_CFG_RST;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign reg_rdata_out = q.rdata;
   assign pm_resp_out.active_ok = (q.st == WD_RUN);
   assign pm_resp_out.shutdown_req = q.shut_pulse;
   assign pm_resp_out.restart_req = q.restart_pulse;
   assign pm_resp_out.frozen = (q.st == WD_FROZEN);
   assign warn_irq_out = q.evt_warn & ~q.mask[`WD_EVT_WARN_BIT];
   assign sec_reset_out = (q.st == WD_SHUTDOWN)
                          && q.cfg[`WD_CFG_SECRST_BIT];
endmodule : wd_watchdog

// ==== wd_host_model.sv ====
`timescale 1ns/10ps
module wd_host_model (
   // Clock
   input wire logic core_clk_in,
   // Bench command, one-cycle pulse
   input wire logic kick_go_in,
   // Bench level, pin held high while set
   input wire logic kick_hold_in,
   // Kick pin, active high
   output logic kick_out
);
   // ----------------------------------------
   // Host kick on the first GPIO
   // ----------------------------------------
   int n = 0;
   // Four cycles wide so the synchroniser cannot miss it
   always @(posedge core_clk_in) begin
      if (kick_go_in) n <= 4;
      else if (n > 0) n <= n - 1;
   end
   // Pin rests low between kicks
   assign kick_out = (n > 0) || kick_hold_in;
endmodule : wd_host_model

// ==== wd_watchdog_monitor.sv ====
`timescale 1ns/10ps
`include "wd_params.svh"
module wd_watchdog_monitor (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_b_in,
   // Watched ports
   input wire wd_pkg::reg_req_t reg_req_in,
   input wire wd_pkg::pm_req_t pm_req_in,
   input wire wd_pkg::pm_resp_t pm_resp_out,
   input wire logic warn_irq_out,
   input wire logic sec_reset_out
);
   import wd_pkg::*;
   // ----------------------------------------
   // Port checks
   // ----------------------------------------
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rst_b_in);
   // Host sets the warn mask bit
   sequence mask_on_s;
      reg_req_in.wr && reg_req_in.addr == `WD_ADDR_MASK && reg_req_in.wdata[3];
   endsequence
   // Timeout announced to the power manager
   sequence shut_s;
      pm_resp_out.shutdown_req;
   endsequence
   shut_pulse_a: assert property (shut_s |=> !pm_resp_out.shutdown_req)
      else $error("shutdown pulse too long");
   shut_stop_a: assert property (shut_s |-> ##[1:2] !pm_resp_out.active_ok)
      else $error("still active after timeout");
   restart_src_a: assert property ($rose(pm_resp_out.restart_req) |->
      $past(pm_req_in.pd_done) || $past(pm_req_in.pd_done, 2))
      else $error("restart without power-down done");
   frozen_hold_a: assert property (pm_resp_out.frozen |=>
      pm_resp_out.frozen && !pm_resp_out.restart_req)
      else $error("left frozen state");
   frozen_quiet_a: assert property (pm_resp_out.frozen |-> !pm_resp_out.active_ok)
      else $error("active while frozen");
   sec_reset_a: assert property (sec_reset_out |-> !pm_resp_out.active_ok)
      else $error("secondary reset while active");
   warn_mask_a: assert property (mask_on_s |-> ##2 !warn_irq_out)
      else $error("masked warning still raised");
   reset_quiet_a: assert property ($rose(rst_b_in) |->
      pm_resp_out == '0 && !warn_irq_out && !sec_reset_out)
      else $error("outputs busy after reset");
endmodule : wd_watchdog_monitor
bind wd_watchdog wd_watchdog_monitor wd_watchdog_monitor_inst (
   .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .reg_req_in(reg_req_in),
   .pm_req_in(pm_req_in), .pm_resp_out(pm_resp_out), .warn_irq_out(warn_irq_out),
   .sec_reset_out(sec_reset_out)
);

// ==== pmic_system_watchdog_test.sv ====
`timescale 1ns/10ps
`include "wd_params.svh"
`define CHK(n,e,a) begin n_checks++; if ((a) !== (e)) begin fail_count++; \
$display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module pmic_system_watchdog_test;
   import wd_pkg::*;
   // ----------------------------------------
   // Stimulus and bench model
   // ----------------------------------------
   logic core_clk_in = 0;
   logic rst_b_in = 0;
   reg_req_t req = '0;
   pm_req_t pm = '0;
   pm_resp_t rsp;
   logic [7:0] rdata, d, m;
   logic xtal_ok = 1, go = 0, hold = 0, kick, warn, sec, ok;
   logic [3:0] cyc = '0;
   logic [3:0] ev;
   int fail_count = 0, n_checks = 0, retry = 3, n_rst = 0, seed = 32'h47b3;
   // Slow ticks: crystal every 4 cycles, internal every 16
   always #20 core_clk_in = ~core_clk_in;
   always @(posedge core_clk_in) begin
      cyc <= cyc + 4'h1;
      if (rsp.restart_req) n_rst <= n_rst + 1;
   end
   assign ev = {warn, rsp.shutdown_req, rsp.restart_req, rsp.active_ok};
   wd_watchdog wd_watchdog_inst (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
      .reg_req_in(req), .reg_rdata_out(rdata), .pm_req_in(pm), .pm_resp_out(rsp),
      .xtal_clk_in(cyc[1]), .int_slow_clk_in(cyc[3]), .xtal_ok_in(xtal_ok),
      .kick_input_pin_in(kick), .otp_wd_unlock_in(1'b0), .warn_irq_out(warn),
      .sec_reset_out(sec));
   wd_host_model wd_host_model_inst (.core_clk_in(core_clk_in), .kick_go_in(go),
      .kick_hold_in(hold), .kick_out(kick));
   // Register strobes last one cycle
   task automatic wr(input logic [8:0] a, input logic [7:0] v);
      @(posedge core_clk_in) req <= {2'b01, a, v};
      @(posedge core_clk_in) req <= '0;
   endtask : wr
   task automatic rd(input logic [8:0] a, output logic [7:0] v);
      @(posedge core_clk_in) req <= {2'b10, a, 8'h00};
      @(posedge core_clk_in) req <= '0;
      @(posedge core_clk_in) #1 v = rdata;
   endtask : rd
   task automatic pls(input logic [1:0] v);
      @(posedge core_clk_in) pm <= v;
      @(posedge core_clk_in) pm <= '0;
   endtask : pls
   // Bounded wait on one event bit
   task automatic wt(input int b, input int lim, input bit must);
      ok = 0;
      for (int i = 0; i < lim && !ok; i++) begin
         @(posedge core_clk_in) #1 ok = (ev[b] === 1'b1);
      end
      if (must && !ok) begin
         fail_count++;
         $display("CHECK FAILED wait %0d exp 1 got 0", b);
         finish_test();
      end
   endtask : wt
   task automatic finish_test();
      $display("checks %0d failures %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : finish_test
   // Main sequence
   initial begin
      repeat (16) @(posedge core_clk_in);
      rst_b_in <= 1;
      rd(`WD_ADDR_FAULT, d); `CHK("fault", 8'h00, d)
      rd(`WD_ADDR_STAT, d); `CHK("stat", 8'hc0, d)
      m = 8'($random(seed));
      wr(`WD_ADDR_MASK, m);
      rd(`WD_ADDR_MASK, d); `CHK("mask", m, d)
      wr(`WD_ADDR_MASK, 8'h00);
      rd(9'h0a5, d); `CHK("unmapped", 8'h00, d)
      $display("test regs done");
      wr(`WD_ADDR_CFG, 8'h06);
      wr(`WD_ADDR_CTRL_D, 8'h01);
      pls(2'b10);
      repeat (200) @(posedge core_clk_in);
      #1 `CHK("early run", 1'b0, rsp.active_ok)
      @(posedge core_clk_in) go <= 1;
      @(posedge core_clk_in) go <= 0;
      wt(0, 40, 1); `CHK("run", 1'b1, rsp.active_ok)
      wr(`WD_ADDR_CTRL_D, 8'h00);
      rd(`WD_ADDR_CTRL_D, d); `CHK("scale", 3'h1, d[2:0])
      wt(3, 3900, 0); `CHK("warn early", 1'b0, ok)
      wt(3, 600, 1); `CHK("warn", 1'b1, warn)
      wr(`WD_ADDR_MASK, 8'h08);
      @(posedge core_clk_in) #1 `CHK("masked", 1'b0, warn)
      wr(`WD_ADDR_MASK, 8'h00);
      wr(`WD_ADDR_EVENT, 8'h08);
      wr(`WD_ADDR_CTRL_F, 8'h01);
      rd(`WD_ADDR_EVENT, d); `CHK("event", 8'h00, d)
      wt(3, 3900, 0); `CHK("warn again", 1'b0, ok)
      $display("test kick done");
      wt(2, 4600, 1);
      retry = retry - 1;
      rd(`WD_ADDR_FAULT, d); `CHK("fault", 8'h01, d)
      `CHK("sec reset", 1'b1, sec)
      `CHK("stopped", 1'b0, rsp.active_ok)
      rd(`WD_ADDR_STAT, d); `CHK("stat", {retry[1:0], 6'h03}, d)
      pls(2'b01);
      repeat (4) @(posedge core_clk_in);
      #1 `CHK("restarts", 1, n_rst)
      $display("test timeout done");
      wr(`WD_ADDR_CTRL_B, 8'h00);
      rd(`WD_ADDR_STAT, d); `CHK("stat", 8'h00, d)
      wr(`WD_ADDR_FAULT, 8'h01);
      rd(`WD_ADDR_FAULT, d); `CHK("fault", 8'h00, d)
      @(posedge core_clk_in) xtal_ok <= 0;
      pls(2'b10);
      repeat (600) @(posedge core_clk_in);
      wr(`WD_ADDR_CTRL_F, 8'h01);
      wt(0, 10, 1); `CHK("run", 1'b1, rsp.active_ok)
      wt(2, 9000, 0); `CHK("slow clock", 1'b0, ok)
      wt(2, 25000, 1);
      pls(2'b01);
      repeat (4) @(posedge core_clk_in);
      #1 `CHK("frozen", 1'b1, rsp.frozen)
      `CHK("restarts", 1, n_rst)
      rd(`WD_ADDR_STAT, d); `CHK("stat", 8'h04, d)
      $display("test freeze done");
      // Mid-run reset leaves frozen; then level mode with the pin held high
      @(posedge core_clk_in) rst_b_in <= 0;
      repeat (4) @(posedge core_clk_in);
      rst_b_in <= 1;
      xtal_ok <= 1;
      @(posedge core_clk_in) #1 `CHK("reset frozen", 1'b0, rsp.frozen)
      rd(`WD_ADDR_STAT, d); `CHK("stat", 8'hc0, d)
      wr(`WD_ADDR_CFG, 8'h03);
      wr(`WD_ADDR_CTRL_D, 8'h01);
      @(posedge core_clk_in) hold <= 1;
      pls(2'b10);
      wt(0, 40, 1); `CHK("level run", 1'b1, rsp.active_ok)
      wt(2, 9000, 0); `CHK("level hold", 1'b0, ok)
      `CHK("level warn", 1'b0, warn)
      `CHK("level sec", 1'b0, sec)
      $display("test level done");
      finish_test();
   end
endmodule : pmic_system_watchdog_test
